// [rps_pkg.sv]
// Constants and types shared by the radio protection switch files
package rps_pkg;
  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  localparam int N_WORK = 4;
  localparam int CH_W = 2;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 32;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 8;
  localparam int RESTORE_NS = 800;
  localparam int RESTORE_CYC = (RESTORE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // Protocol byte layout and reset values
  // ----------------------------------------------------------------
  localparam int CODE_LSB = 6;
  localparam int CODE_W = 2;
  localparam int CHAN_LSB = 0;
  localparam logic STATE_RST = 1'b0;

  typedef enum logic [1:0]
  {
    REQ_NONE = 2'h0,
    REQ_EW = 2'h1,
    REQ_SD = 2'h2,
    REQ_SF = 2'h3
  } req_t;
endpackage

// [rps_fifo.sv]
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic mclk, // Clock
  input wire logic nrst, // Sync reset, low
  input wire logic in_valid, // Write request
  output logic in_ready, // Space free
  input wire logic [WIDTH-1:0] in_data, // Write data
  output logic out_valid, // Data available
  input wire logic out_ready, // Reader takes data
  output logic [WIDTH-1:0] out_data // Head word
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic wr_en;
  logic rd_en;

  assign in_ready = q.cnt != (AW+1)'(DEPTH);
  assign out_valid = q.cnt != '0;
  assign out_data = q.mem[q.rd];
  assign wr_en = in_valid && in_ready;
  assign rd_en = out_valid && out_ready;

  always_comb
  begin
    d = q;
    if (wr_en)
    begin
      d.mem[q.wr] = in_data;
      d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
    end
    if (rd_en)
      d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
    d.cnt = q.cnt + (AW+1)'(wr_en) - (AW+1)'(rd_en);
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      q <= '0;
    else
      q <= d;
  end
endmodule
`default_nettype wire

// [radio_interface_monitor.sv]
// Receive-side supervision of one radio physical interface
`timescale 1ns/1ps
`default_nettype none
module radio_interface_monitor (
  input wire logic mclk, // Clock
  input wire logic nrst, // Sync reset, low
  input wire logic rx_signal_ok, // Receiver delivers a usable signal
  input wire logic demod_ok, // Demodulator input present
  input wire logic [7:0] rx_level, // Received power level
  input wire logic [7:0] fec_activity, // Error-correction activity
  input wire logic [7:0] level_floor, // Lowest acceptable level
  input wire logic [7:0] fec_limit, // Highest acceptable activity
  input wire logic rec_timing, // Recovered timing
  output logic los, // Receive loss of signal
  output logic early_warning, // Early-warning switching request
  output logic power_raise, // Transmit power increase request
  output logic timing_ref // Recovered timing toward timing source
);
  typedef struct packed {
    logic los;
    logic ew;
    logic raise;
    logic timing;
  } mon_state_t;

  mon_state_t q;
  mon_state_t d;

  always_comb
  begin
    d.los = !rx_signal_ok || !demod_ok; // [R13]
    d.raise = rx_level < level_floor; // [R14]
    d.ew = d.raise || (fec_activity > fec_limit); // [R14]
    d.timing = rec_timing; // [R15]
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      q <= '0;
    else
      q <= d;
  end

  assign los = q.los;
  assign early_warning = q.ew;
  assign power_raise = q.raise;
  assign timing_ref = q.timing;
endmodule
`default_nettype wire

// [radio_protection_switch.sv]
// Radio protection switch: n working lines, one protection line
// Operation
// [R1] Working lines are protected by the protection line against equipment and propagation faults.
// [R2] Working paths join only equal indices, and the protection line pairs with the occasional port while no channel is bridged or switched.
// [R3] Any working tributary may feed the protection line and the protection line may feed any working tributary.
// [R4] No other path such as line to line, tributary to tributary or occasional to working is ever built.
// [R5] Every switched byte passes unchanged.
// [R6] Each tributary working input is copied to its own working line and to the transmit distributor.
// [R7] A working channel that needs protection is bridged from the distributor onto the protection line.
// [R8] Early warning, signal degrade, signal fail and radio interface failure mark a working line as bad.
// [R9] A bad line raises a request to the far end over the protocol channel, and a far-end request starts switching.
// [R10] Status and switch requests travel as one overhead byte each.
// [R11] In one-plus-one mode channel zero is bridged permanently and no requests are sent.
// [R12] The receive changeover is made only on a frame boundary so that it is hitless.
// [R13] Receive loss of signal is raised when the received signal or demodulator input fails and is reported.
// [R14] Exceeded receive thresholds produce power-increase and early-warning requests toward overhead access.
// [R15] Recovered timing is offered to the equipment timing source.
// [R16] Physical status of the switch is reported to equipment management.
// [R17] A released request returns the channel to its working line after a hold time, by fixed priority; only the bridge is held, not the receive selection.
`timescale 1ns/1ps
`default_nettype none
module radio_protection_switch (
  input wire logic mclk, // 125 MHz clock
  input wire logic nrst, // Sync reset, low
  input wire logic [rps_pkg::N_WORK-1:0][rps_pkg::DATA_W-1:0] trib_work_in, // Tributary working in
  output logic [rps_pkg::N_WORK-1:0][rps_pkg::DATA_W-1:0] trib_work_out, // Tributary working out
  input wire logic [rps_pkg::DATA_W-1:0] occ_in, // Occasional traffic in
  output logic [rps_pkg::DATA_W-1:0] occ_out, // Occasional traffic out
  input wire logic [rps_pkg::N_WORK-1:0][rps_pkg::DATA_W-1:0] line_work_in, // Working lines in
  output logic [rps_pkg::N_WORK-1:0][rps_pkg::DATA_W-1:0] line_work_out, // Working lines out
  input wire logic [rps_pkg::DATA_W-1:0] line_prot_in, // Protection line in
  output logic [rps_pkg::DATA_W-1:0] line_prot_out, // Protection line out
  input wire logic frame_start, // Common frame boundary
  input wire logic one_plus_one, // One-plus-one mode
  input wire logic [rps_pkg::N_WORK-1:0] signal_degrade, // Degrade per working line
  input wire logic [rps_pkg::N_WORK-1:0] signal_fail, // Fail per working line
  input wire logic [rps_pkg::N_WORK:0] rx_signal_ok, // Receiver ok, top bit protection
  input wire logic [rps_pkg::N_WORK:0] demod_ok, // Demodulator input ok
  input wire logic [rps_pkg::N_WORK:0][7:0] rx_level, // Received levels
  input wire logic [rps_pkg::N_WORK:0][7:0] fec_activity, // Error-correction activity
  input wire logic [7:0] level_floor, // Level threshold
  input wire logic [7:0] fec_limit, // Activity threshold
  input wire logic [rps_pkg::N_WORK:0] rec_timing, // Recovered timing
  output logic [rps_pkg::N_WORK:0] los_out, // Loss of signal
  output logic [rps_pkg::N_WORK:0] early_warning_out, // Early warning
  output logic [rps_pkg::N_WORK:0] power_raise, // Power increase request
  output logic [rps_pkg::N_WORK:0] timing_ref, // Recovered timing out
  input wire logic proto_rx_valid, // Far-end protocol byte valid
  input wire logic [rps_pkg::DATA_W-1:0] proto_rx_data, // Far-end protocol byte
  output logic proto_tx_valid, // Protocol byte to send
  input wire logic proto_tx_ready, // Overhead access takes byte
  output logic [rps_pkg::DATA_W-1:0] proto_tx_data, // Protocol byte
  output logic bridge_active, // Protection line carries a working channel
  output logic [rps_pkg::CH_W-1:0] bridge_channel, // Bridged channel
  output logic rx_switched, // A tributary takes the protection line
  output logic [rps_pkg::CH_W-1:0] rx_channel, // Switched channel
  output logic [1:0] local_request, // Worst local request code
  output logic [1:0] far_request // Last far-end request code
);
  localparam int N = rps_pkg::N_WORK;
  localparam int W = rps_pkg::DATA_W;
  localparam int CW = rps_pkg::CH_W;

  typedef struct packed {
    logic [N-1:0][W-1:0] line_work;
    logic [W-1:0] line_prot;
    logic [N-1:0][W-1:0] trib_work;
    logic [W-1:0] occ;
    logic bridge_on;
    logic [CW-1:0] bridge_ch;
    logic rx_on;
    logic [CW-1:0] rx_ch;
    rps_pkg::req_t loc_code;
    logic [CW-1:0] loc_ch;
    rps_pkg::req_t far_code;
    logic [CW-1:0] far_ch;
    rps_pkg::req_t sent_code;
    logic [CW-1:0] sent_ch;
    logic [rps_pkg::CNT_W-1:0] wtr;
  } sw_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic rps_pkg::req_t line_code(input logic sf, input logic sd, input logic ew);
    if (sf)
      line_code = rps_pkg::REQ_SF;
    else if (sd)
      line_code = rps_pkg::REQ_SD;
    else if (ew)
      line_code = rps_pkg::REQ_EW;
    else
      line_code = rps_pkg::REQ_NONE;
  endfunction

  function automatic logic [W-1:0] proto_byte(input rps_pkg::req_t c, input logic [CW-1:0] ch);
    proto_byte = (W'(c) << rps_pkg::CODE_LSB) | (W'(ch) << rps_pkg::CHAN_LSB);
  endfunction

  sw_state_t q;
  sw_state_t d;
  logic [N:0] los_w;
  logic [N:0] ew_w;
  rps_pkg::req_t top_code;
  logic [CW-1:0] top_ch;
  rps_pkg::req_t ch0_code;
  logic push;
  logic push_ready;
  logic prot_bad;

  // ----------------------------------------------------------------
  // Radio interface supervision, one per line
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g <= N; g++)
    begin : mon
      radio_interface_monitor u_mon (
        .mclk(mclk),
        .nrst(nrst),
        .rx_signal_ok(rx_signal_ok[g]),
        .demod_ok(demod_ok[g]),
        .rx_level(rx_level[g]),
        .fec_activity(fec_activity[g]),
        .level_floor(level_floor),
        .fec_limit(fec_limit),
        .rec_timing(rec_timing[g]),
        .los(los_w[g]),
        .early_warning(ew_w[g]),
        .power_raise(power_raise[g]),
        .timing_ref(timing_ref[g])
      );
    end
  endgenerate

  assign los_out = los_w; // [R13]
  assign early_warning_out = ew_w; // [R14]
  assign prot_bad = los_w[N];

  // ----------------------------------------------------------------
  // Worst local request, higher code first, then lower index
  // ----------------------------------------------------------------
  always_comb
  begin
    rps_pkg::req_t c;
    c = rps_pkg::REQ_NONE;
    top_code = rps_pkg::REQ_NONE;
    top_ch = '0;
    for (int i = 0; i < N; i++)
    begin
      c = line_code(signal_fail[i] || los_w[i], signal_degrade[i], ew_w[i]); // [R8]
      if (c > top_code) // [R17]
      begin
        top_code = c;
        top_ch = CW'(i);
      end
    end
    ch0_code = line_code(signal_fail[0] || los_w[0], signal_degrade[0], ew_w[0]); // [R8]
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    push = 1'b0;
    d.line_work = trib_work_in; // [R6] [R2] [R5]
    d.loc_code = top_code;
    d.loc_ch = top_ch;
    if (proto_rx_valid)
    begin
      d.far_code = rps_pkg::req_t'(proto_rx_data[rps_pkg::CODE_LSB +: rps_pkg::CODE_W]); // [R10]
      d.far_ch = proto_rx_data[rps_pkg::CHAN_LSB +: CW];
    end

    // Transmit bridge onto the protection line
    if (one_plus_one)
    begin
      d.bridge_on = 1'b1; // [R11]
      d.bridge_ch = '0;
      d.wtr = '0;
    end
    else if (q.far_code != rps_pkg::REQ_NONE)
    begin
      d.bridge_on = 1'b1; // [R9] [R7] [R1]
      d.bridge_ch = q.far_ch;
      d.wtr = '0;
    end
    else if (q.bridge_on)
    begin
      if (q.wtr == rps_pkg::CNT_W'(rps_pkg::RESTORE_CYC - 1))
      begin
        d.bridge_on = rps_pkg::STATE_RST; // [R17]
        d.wtr = '0;
      end
      else
        d.wtr = q.wtr + 1'b1;
    end
    d.line_prot = q.bridge_on ? trib_work_in[q.bridge_ch] : occ_in; // [R3] [R2] [R4]

    // Receive selection changes only on a frame boundary
    if (frame_start)
    begin
      if (one_plus_one)
      begin
        d.rx_on = (ch0_code != rps_pkg::REQ_NONE) && !prot_bad; // [R12] [R11]
        d.rx_ch = '0;
      end
      else if (top_code != rps_pkg::REQ_NONE && !prot_bad)
      begin
        d.rx_on = 1'b1; // [R12] [R1]
        d.rx_ch = top_ch;
      end
      else
        d.rx_on = rps_pkg::STATE_RST; // [R17]
    end
    for (int i = 0; i < N; i++)
    begin
      if (q.rx_on && q.rx_ch == CW'(i))
        d.trib_work[i] = line_prot_in; // [R3]
      else
        d.trib_work[i] = line_work_in[i]; // [R2]
    end
    d.occ = q.rx_on ? '0 : line_prot_in; // [R4] [R2]

    // Request to the far end when the worst request differs from the last one queued and the queue has room, except in one-plus-one mode
    if (!one_plus_one && push_ready &&
        (q.loc_code != q.sent_code || q.loc_ch != q.sent_ch))
    begin
      push = 1'b1; // [R9] [R11]
      d.sent_code = q.loc_code;
      d.sent_ch = q.loc_ch;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      q <= '0;
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // Protocol byte queue toward overhead access
  // ----------------------------------------------------------------
  rps_fifo #(
    .WIDTH(W),
    .DEPTH(rps_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(proto_byte(q.loc_code, q.loc_ch)), // [R10]
    .out_valid(proto_tx_valid),
    .out_ready(proto_tx_ready),
    .out_data(proto_tx_data)
  );

  // ----------------------------------------------------------------
  // Outputs and status
  // ----------------------------------------------------------------
  assign line_work_out = q.line_work;
  assign line_prot_out = q.line_prot;
  assign trib_work_out = q.trib_work;
  assign occ_out = q.occ;
  assign bridge_active = q.bridge_on; // [R16]
  assign bridge_channel = q.bridge_ch; // [R16]
  assign rx_switched = q.rx_on; // [R16]
  assign rx_channel = q.rx_ch; // [R16]
  assign local_request = q.loc_code; // [R16]
  assign far_request = q.far_code; // [R16]

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [W-1:0] bridged_src;
  logic [W-1:0] switched_out;
  logic [CW-1:0] far_ch_seen;
  assign bridged_src = trib_work_in[q.bridge_ch];
  assign far_ch_seen = q.far_ch;
  assign switched_out = q.trib_work[q.rx_ch];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  work_copy_a: assert property ( // [R6]
    $past(nrst) |-> line_work_out == $past(trib_work_in))
    else $error("working line copy differs from tributary input");

  bridge_path_a: assert property ( // [R7]
    $past(nrst) && $past(bridge_active) |-> line_prot_out == $past(bridged_src))
    else $error("protection line does not carry the bridged channel");

  occ_path_a: assert property ( // [R2]
    $past(nrst) && !$past(bridge_active) |-> line_prot_out == $past(occ_in))
    else $error("protection line does not carry occasional traffic");

  occ_block_a: assert property ( // [R4]
    $past(nrst) && $past(rx_switched) |-> occ_out == '0)
    else $error("occasional output leaks working traffic");

  rx_select_a: assert property ( // [R3]
    $past(nrst) && $past(rx_switched) && rx_switched && rx_channel == $past(rx_channel)
    |-> switched_out == $past(line_prot_in))
    else $error("switched tributary does not take the protection line");

  one_plus_a: assert property ( // [R11]
    one_plus_one |-> !push &&
    (!$past(nrst) || !$past(one_plus_one) || (bridge_active && bridge_channel == '0)))
    else $error("one-plus-one mode sends requests or lacks bridge");

  request_send_a: assert property ( // [R9]
    push |=> proto_tx_valid)
    else $error("local request not queued toward the far end");

  far_bridge_a: assert property ( // [R9]
    proto_rx_valid && !one_plus_one &&
    proto_rx_data[rps_pkg::CODE_LSB +: rps_pkg::CODE_W] != 2'h0
    ##1 !one_plus_one |=> bridge_active && bridge_channel == $past(far_ch_seen))
    else $error("far-end request did not bridge the channel");

  restore_hold_a: assert property ( // [R17]
    $past(nrst) && $fell(bridge_active) |-> $past(q.wtr) == rps_pkg::CNT_W'(rps_pkg::RESTORE_CYC - 1))
    else $error("bridge released before the hold time");

  hitless_a: assert property ( // [R12]
    $past(nrst) && $changed(rx_switched) |-> $past(frame_start))
    else $error("receive changeover away from a frame boundary");

  detect_fail_a: assert property ( // [R8]
    signal_fail[0] |=> local_request == 2'h3)
    else $error("signal fail not reported as top request");

  los_raise_a: assert property ( // [R13]
    !rx_signal_ok[0] |=> los_out[0])
    else $error("loss of signal not raised");

  bridge_cov_c: cover property (!bridge_active ##1 bridge_active ##[1:4] !proto_rx_valid);
  restore_cov_c: cover property ($fell(bridge_active));
  rx_switch_cov_c: cover property ($rose(rx_switched));
  fifo_full_cov_c: cover property (!push_ready);
endmodule
`default_nettype wire

// [far_end_switch.sv]
// Behavioural model of the far-end protection switch on the protocol channel
`timescale 1ns/1ps
`default_nettype none
module far_end_switch (
  input wire logic mclk, // Clock
  input wire logic nrst, // Sync reset, low
  input wire logic [1:0] pace, // 0 prompt, 1 slow, 2 stalled
  input wire logic send, // Issue one request byte
  input wire logic [7:0] send_byte, // Byte to issue
  input wire logic tx_valid, // Byte offered by near end
  input wire logic [7:0] tx_data, // Offered byte
  output logic tx_ready, // Byte accepted
  output logic rx_valid, // Request byte valid
  output logic [7:0] rx_data, // Request byte
  output int rx_cnt, // Bytes accepted
  output logic [7:0] last_byte // Latest byte accepted
);
  // --------
  // Channel
  // --------
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_cnt <= 0;
      last_byte <= 8'h00;
    end
    else
    begin
      tx_ready <= (pace == 2'h0) || (pace == 2'h1 && !tx_ready);
      rx_valid <= send;
      // Idle byte lane toggles so a stale value is never read as a request
      rx_data <= send ? send_byte : ~rx_data;
      if (tx_valid && tx_ready)
      begin
        rx_cnt <= rx_cnt + 1;
        last_byte <= tx_data;
      end
    end
  end
endmodule
`default_nettype wire

// [radio_protection_switch_tb.sv]
// Self-checking bench for the radio protection switch
`timescale 1ns/1ps
`default_nettype none
module radio_protection_switch_tb;
  // --------
  // Signals and tasks
  // --------
  typedef logic [rps_pkg::N_WORK-1:0][rps_pkg::DATA_W-1:0] lanes_t;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  lanes_t trib_work_in = '0, line_work_in = '0, trib_work_out, line_work_out;
  logic [7:0] occ_in = '0, line_prot_in = '0, level_floor = 8'h40, fec_limit = 8'hc0, send_byte = '0;
  logic [7:0] occ_out, line_prot_out, proto_rx_data, proto_tx_data, last_byte;
  logic frame_start = 1'b0, one_plus_one = 1'b0, send = 1'b0;
  logic proto_rx_valid, proto_tx_valid, proto_tx_ready, bridge_active, rx_switched;
  logic [3:0] signal_degrade = '0, signal_fail = '0;
  logic [4:0] rx_signal_ok = '1, demod_ok = '1, rec_timing = '0;
  logic [4:0] los_out, early_warning_out, power_raise, timing_ref;
  logic [4:0][7:0] rx_level = {5{8'h80}}, fec_activity = {5{8'h10}};
  logic [1:0] pace = 2'h0, bridge_channel, rx_channel, local_request, far_request;
  int rx_cnt, k0, c, n;
  int error_cnt = 0;
  int comparisons = 0;

  always #4 mclk = ~mclk;

  radio_protection_switch i_dut (
    .mclk, .nrst, .trib_work_in, .trib_work_out, .occ_in, .occ_out, .line_work_in, .line_work_out,
    .line_prot_in, .line_prot_out, .frame_start, .one_plus_one, .signal_degrade, .signal_fail,
    .rx_signal_ok, .demod_ok, .rx_level, .fec_activity, .level_floor, .fec_limit, .rec_timing,
    .los_out, .early_warning_out, .power_raise, .timing_ref, .proto_rx_valid, .proto_rx_data,
    .proto_tx_valid, .proto_tx_ready, .proto_tx_data, .bridge_active, .bridge_channel,
    .rx_switched, .rx_channel, .local_request, .far_request
  );
  far_end_switch i_far (
    .mclk, .nrst, .pace, .send, .send_byte, .tx_valid(proto_tx_valid), .tx_data(proto_tx_data),
    .tx_ready(proto_tx_ready), .rx_valid(proto_rx_valid), .rx_data(proto_rx_data), .rx_cnt, .last_byte
  );

  task automatic tally_and_finish();
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  task automatic bound(input int w, input int lim);
    if (w >= lim)
    begin
      $display("unexpected timeout: expected below %0d seen %0d", lim, w);
      error_cnt++;
      tally_and_finish();
    end
  endtask

  // Waits m rising edges, then samples at the falling edge
  task automatic cyc(input int m);
    repeat (m) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic wait_byte(input int base);
    int w;
    for (w = 0; w < 80 && rx_cnt == base; w++)
      cyc(1);
    bound(w, 80);
  endtask

  task automatic far(input logic [7:0] b);
    @(posedge mclk);
    send <= 1'b1;
    send_byte <= b;
    @(posedge mclk);
    send <= 1'b0;
    cyc(3);
  endtask

  task automatic frame();
    @(posedge mclk);
    frame_start <= 1'b1;
    @(posedge mclk);
    frame_start <= 1'b0;
    cyc(1);
  endtask

  task automatic apply(input int kind, input int ch, input logic on);
    case (kind)
      0: signal_fail[ch] <= on;
      1: signal_degrade[ch] <= on;
      2: rx_level[ch] <= on ? 8'h20 : 8'h80;
      default: rx_signal_ok[ch] <= ~on;
    endcase
  endtask

  function automatic logic [1:0] kcode(input int kind);
    return kind == 1 ? rps_pkg::REQ_SD : kind == 2 ? rps_pkg::REQ_EW : rps_pkg::REQ_SF;
  endfunction

  // --------
  // Sequence
  // --------
  initial
  begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    cyc(0);
    check("bridge_active", 8'h0, 8'(bridge_active));
    check("proto_tx_valid", 8'h0, 8'(proto_tx_valid));
    for (n = 0; n < 2; n++)
    begin
      @(posedge mclk);
      trib_work_in <= n ? ~trib_work_in : 32'h8c4a2f01;
      line_work_in <= n ? ~line_work_in : 32'h17e93b60;
      occ_in <= n ? ~occ_in : 8'hd3;
      line_prot_in <= n ? ~line_prot_in : 8'h6e;
      cyc(1);
      for (c = 0; c < 4; c++)
      begin
        check("line_work_out", trib_work_in[c], line_work_out[c]);
        check("trib_work_out", line_work_in[c], trib_work_out[c]);
      end
      check("occ_out", line_prot_in, occ_out);
      check("line_prot_out", occ_in, line_prot_out);
    end
    for (c = 0; c < 4; c++)
    begin
      far({2'(c % 3 + 1), 4'h0, 2'(c)});
      check("far_request", 8'(c % 3 + 1), 8'(far_request));
      check("bridge_active", 8'h1, 8'(bridge_active));
      check("bridge_channel", 8'(c), 8'(bridge_channel));
      cyc(1);
      check("line_prot_out", trib_work_in[c], line_prot_out);
      check("line_work_out", trib_work_in[c], line_work_out[c]);
    end
    far(8'h00);
    check("far_request", 8'h0, 8'(far_request));
    for (n = 0; n < 300 && bridge_active === 1'b1; n++)
      cyc(1);
    bound(n, 300);
    check("restore hold", 8'h1, 8'(n >= rps_pkg::RESTORE_CYC - 4 && n <= rps_pkg::RESTORE_CYC + 1));
    cyc(1);
    check("line_prot_out", occ_in, line_prot_out);
    for (n = 0; n < 16; n++)
    begin
      c = n % 4;
      k0 = rx_cnt;
      @(posedge mclk);
      pace <= 2'(n % 2);
      apply(n / 4, c, 1'b1);
      wait_byte(k0);
      check("request byte", {kcode(n / 4), 4'h0, 2'(c)}, last_byte);
      check("local_request", 8'(kcode(n / 4)), 8'(local_request));
      k0 = rx_cnt;
      @(posedge mclk);
      apply(n / 4, c, 1'b0);
      wait_byte(k0);
      check("release byte", 8'h00, last_byte);
    end
    k0 = rx_cnt;
    @(posedge mclk);
    signal_fail <= 4'hc;
    signal_degrade <= 4'h2;
    line_prot_in <= 8'ha5;
    wait_byte(k0);
    check("priority byte", 8'hc2, last_byte);
    cyc(3);
    check("rx_switched", 8'h0, 8'(rx_switched));
    frame();
    check("rx_switched", 8'h1, 8'(rx_switched));
    check("rx_channel", 8'h2, 8'(rx_channel));
    check("trib_work_out", 8'ha5, trib_work_out[2]);
    check("occ_out", 8'h00, occ_out);
    check("trib_work_out", line_work_in[1], trib_work_out[1]);
    k0 = rx_cnt;
    @(posedge mclk);
    signal_fail <= 4'h0;
    signal_degrade <= 4'h0;
    wait_byte(k0);
    frame();
    check("rx_switched", 8'h0, 8'(rx_switched));
    cyc(1);
    check("occ_out", 8'ha5, occ_out);
    for (c = 0; c < 5; c++)
    begin
      @(posedge mclk);
      demod_ok[c] <= 1'b0;
      cyc(3);
      check("los_out", 8'(5'h01 << c), 8'(los_out));
      @(posedge mclk);
      demod_ok[c] <= 1'b1;
      cyc(3);
    end
    for (n = 0; n < 3; n++)
    begin
      @(posedge mclk);
      rx_level[4] <= n == 0 ? 8'h3f : 8'h40;
      fec_activity[4] <= n == 1 ? 8'hc1 : 8'hc0;
      rec_timing <= n[0] ? 5'h0a : 5'h15;
      cyc(3);
      check("power_raise", n == 0 ? 8'h10 : 8'h00, 8'(power_raise));
      check("early_warning_out", n < 2 ? 8'h10 : 8'h00, 8'(early_warning_out));
      check("timing_ref", n[0] ? 8'h0a : 8'h15, 8'(timing_ref));
    end
    k0 = rx_cnt;
    @(posedge mclk);
    one_plus_one <= 1'b1;
    signal_fail[1] <= 1'b1;
    cyc(8);
    check("bridge_active", 8'h1, 8'(bridge_active));
    check("bridge_channel", 8'h0, 8'(bridge_channel));
    check("line_prot_out", trib_work_in[0], line_prot_out);
    check("tx byte count", 8'(k0), 8'(rx_cnt));
    @(posedge mclk);
    one_plus_one <= 1'b0;
    signal_fail[1] <= 1'b0;
    for (n = 0; n < 300 && bridge_active === 1'b1; n++)
      cyc(1);
    bound(n, 300);
    cyc(4);
    k0 = rx_cnt;
    @(posedge mclk);
    pace <= 2'h2;
    for (n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      signal_fail[0] <= ~signal_fail[0];
      @(posedge mclk);
    end
    cyc(4);
    check("proto_tx_valid", 8'h1, 8'(proto_tx_valid));
    @(posedge mclk);
    pace <= 2'h0;
    for (n = 0; n < 200 && proto_tx_valid !== 1'b0; n++)
      cyc(1);
    bound(n, 200);
    cyc(4);
    check("fifo bytes", 8'h1, 8'(rx_cnt - k0 >= rps_pkg::FIFO_DEPTH && rx_cnt - k0 <= 40));
    check("last byte", 8'h00, last_byte);
    @(posedge mclk);
    pace <= 2'h2;
    signal_fail[3] <= 1'b1;
    cyc(4);
    @(posedge mclk);
    nrst <= 1'b0;
    cyc(2);
    check("proto_tx_valid", 8'h0, 8'(proto_tx_valid));
    check("local_request", 8'h0, 8'(local_request));
    tally_and_finish();
  end
endmodule
`default_nettype wire
